/* core/tam_regs.v */
// Upper management register bank of a ten-bit / 1000BASE-X coding unit, reached over MDIO.
// Assumes MDC and MDIO input come from pads; the coding logic sits outside and uses the
// controls, timer pulses and pattern word driven here.
`include "tam_regs_map.vh"

////////////////////////////////////////////////////////////////////////////////
module tam_regs
(
	// Clock and reset
	input  wire        I_CLK_SYS,
	input  wire        I_RST_B,
	// MDIO pins
	input  wire        I_MDC,
	input  wire        I_MDIO,
	output reg         O_MDIO,
	output reg         O_MDIO_OE,
	input  wire [4:0]  I_PHY_ADDR,
	// Mode and link-partner state from the negotiation logic
	input  wire        I_MODE_BASEX,
	input  wire [15:0] I_PARTNER_BASE,
	input  wire [15:0] I_PARTNER_NP,
	input  wire        I_PAGE_STROBE,
	input  wire        I_NONEG_PARTNER,
	input  wire        I_NP_SENT,
	input  wire        I_BASE_TOGGLE,
	// Controls to the coding logic and timer starts from it
	output reg         O_SUB_RESET,
	output reg         O_RX_RD_DIS,
	output reg         O_TX_RD_DIS,
	output reg         O_AN_SENSE_DONE,
	output reg         O_GO_LINK_DONE,
	output reg         O_SYNC_FAIL_DONE,
	input  wire        I_GO_LINK_START,
	input  wire        I_SYNC_FAIL_START,
	output reg         O_JITTER_ACTIVE,
	output reg  [9:0]  O_JITTER_WORD,
	output reg  [15:0] O_NP_TX_WORD
);

////////////////////////////////////////////////////////////////////////////////
// Timer lengths in system clock cycles
localparam [20:0] GO_LINK_LONG = `TAM_GO_LINK_LONG;
localparam [20:0] GO_LINK_SHORT = `TAM_GO_LINK_CYCLES;

localparam ST_IDLE = 3'h0;
localparam ST_HDR  = 3'h1;
localparam ST_TA   = 3'h2;
localparam ST_RD   = 3'h3;
localparam ST_WR   = 3'h4;

function [20:0] dec21;
	input [20:0] v;
	begin
		dec21 = (v == 21'h000000) ? 21'h000000 : v - 21'h000001;
	end
endfunction

function [19:0] rot20;
	input [19:0] v;
	begin
		rot20 = {v[9:0], v[19:10]};
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers and MDC edge finder
reg        mdc_s1_r;
reg        mdc_s2_r;
reg        mdc_s3_r;
reg        mdi_s1_r;
reg        mdi_s2_r;
wire       mdc_rise = mdc_s2_r & ~mdc_s3_r;
wire       mdc_fall = ~mdc_s2_r & mdc_s3_r;

always @(posedge I_CLK_SYS)
begin
	if (!I_RST_B)
	begin
		mdc_s1_r <= 1'b0;
		mdc_s2_r <= 1'b0;
		mdc_s3_r <= 1'b0;
		mdi_s1_r <= 1'b1;
		mdi_s2_r <= 1'b1;
	end
	else
	begin
		mdc_s1_r <= I_MDC;
		mdc_s2_r <= mdc_s1_r;
		mdc_s3_r <= mdc_s2_r;
		mdi_s1_r <= I_MDIO;
		mdi_s2_r <= mdi_s1_r;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Registers
reg [15:0] np_tx_r;
reg [15:0] jit_r;
reg [15:0] ctrl_r;
reg        page_rx_r;
reg        toggle_r;

wire [15:0] base_t_view = {I_PARTNER_BASE[15], I_PARTNER_BASE[14], 1'b0,
	I_PARTNER_BASE[12], I_PARTNER_BASE[11:10], 10'h001};
wire [15:0] base_x_view = {I_PARTNER_BASE[15], 1'b0, I_PARTNER_BASE[13:12],
	3'h0, I_PARTNER_BASE[8:7], I_PARTNER_BASE[6:5], 5'h00};
wire [15:0] np_rx_x_view = {I_PARTNER_NP[15], 1'b0, I_PARTNER_NP[13:11],
	I_PARTNER_NP[10:0]};
wire [15:0] np_tx_view = I_MODE_BASEX ? {np_tx_r[15:12], toggle_r, np_tx_r[10:0]} : np_tx_r;

////////////////////////////////////////////////////////////////////////////////
// MDIO frame engine
reg [2:0]  st_r;
reg [5:0]  cnt_r;
reg [13:0] hdr_r;
reg [15:0] sh_r;
reg        hit_r;
reg        rd_clr_r;
reg [5:0]  pre_r;

wire [4:0] reg_addr = hdr_r[4:0];
wire [15:0] np_tx_wmask = I_MODE_BASEX ? `TAM_NP_TX_WMASK : 16'hFFFF;
reg [15:0] rd_val;
always @*
begin
	rd_val = 16'h0000;
	case (reg_addr)
		`TAM_REG_PARTNER_BASE: rd_val = I_MODE_BASEX ? base_x_view : base_t_view;
		`TAM_REG_EXPANSION: rd_val = {13'h0000, 1'b1, page_rx_r, 1'b0};
		`TAM_REG_NP_TX: rd_val = np_tx_view;
		`TAM_REG_PARTNER_NP: rd_val = I_MODE_BASEX ? np_rx_x_view : I_PARTNER_NP;
		`TAM_REG_EXT_STATUS: rd_val = `TAM_EXT_STATUS_VAL;
		`TAM_REG_JITTER: rd_val = jit_r;
		`TAM_REG_LINK_CTRL: rd_val = ctrl_r;
		default: rd_val = 16'h0000;
	endcase
end

always @(posedge I_CLK_SYS)
begin
	if (!I_RST_B)
	begin
		st_r      <= ST_IDLE;
		cnt_r     <= 6'h00;
		hdr_r     <= 14'h0000;
		sh_r      <= 16'h0000;
		hit_r     <= 1'b0;
		rd_clr_r  <= 1'b0;
		pre_r     <= 6'h00;
		O_MDIO    <= 1'b1;
		O_MDIO_OE <= 1'b0;
		np_tx_r   <= `TAM_NP_TX_RESET;
		jit_r     <= `TAM_JIT_RESET;
		ctrl_r    <= `TAM_CTRL_RESET;
	end
	else
	begin
		rd_clr_r <= 1'b0;
		// Sample on rising MDC, drive on falling
		if (mdc_rise)
		begin
			case (st_r)
				ST_IDLE:
				begin
					// Preamble is optional, so a start after any ones is taken
					if (!mdi_s2_r && pre_r != 6'h00)
					begin
						st_r  <= ST_HDR;
						cnt_r <= 6'h00;
						hdr_r <= 14'h0000;
					end
					pre_r <= mdi_s2_r ? 6'h01 : 6'h00;
				end
				ST_HDR:
				begin
					hdr_r <= {hdr_r[12:0], mdi_s2_r};
					cnt_r <= cnt_r + 6'h01;
					if (cnt_r == 6'h0C)
					begin
						st_r  <= ST_TA;
						cnt_r <= 6'h00;
						hit_r <= (hdr_r[8:4] == I_PHY_ADDR) && hdr_r[11] == 1'b1;
					end
				end
				ST_TA:
				begin
					cnt_r <= cnt_r + 6'h01;
					if (cnt_r == 6'h00 && hdr_r[11:10] == 2'b10 && hit_r)
					begin
						sh_r     <= rd_val;
						rd_clr_r <= (reg_addr == `TAM_REG_EXPANSION);
					end
					if (cnt_r == 6'h01)
					begin
						cnt_r <= 6'h00;
						st_r  <= (hdr_r[11:10] == 2'b10) ? ST_RD : ST_WR;
					end
				end
				ST_RD:
				begin
					cnt_r <= cnt_r + 6'h01;
					if (cnt_r == 6'h0F)
						st_r <= ST_IDLE;
				end
				ST_WR:
				begin
					sh_r  <= {sh_r[14:0], mdi_s2_r};
					cnt_r <= cnt_r + 6'h01;
					if (cnt_r == 6'h0F)
					begin
						st_r <= ST_IDLE;
						if (hit_r && hdr_r[11:10] == 2'b01)
						begin
							if (reg_addr == `TAM_REG_NP_TX)
								np_tx_r <= {sh_r[14:0], mdi_s2_r} & np_tx_wmask;
							if (reg_addr == `TAM_REG_JITTER)
								jit_r <= {sh_r[14:0], mdi_s2_r} & `TAM_JIT_WMASK;
							if (reg_addr == `TAM_REG_LINK_CTRL)
								ctrl_r <= {sh_r[14:0], mdi_s2_r} & `TAM_CTRL_WMASK;
						end
					end
				end
				default: st_r <= ST_IDLE;
			endcase
		end
		if (mdc_fall)
		begin
			if (st_r == ST_TA && cnt_r == 6'h01 && hit_r && hdr_r[11:10] == 2'b10)
			begin
				O_MDIO_OE <= 1'b1;
				O_MDIO    <= 1'b0;
			end
			else if (st_r == ST_RD && hit_r)
			begin
				O_MDIO_OE <= 1'b1;
				O_MDIO    <= sh_r[15];
				sh_r      <= {sh_r[14:0], 1'b0};
			end
			else
			begin
				O_MDIO_OE <= 1'b0;
				O_MDIO    <= 1'b1;
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Page received and toggle
always @(posedge I_CLK_SYS)
begin
	if (!I_RST_B)
	begin
		page_rx_r <= 1'b0;
		toggle_r  <= 1'b0;
	end
	else
	begin
		// New page wins over a read clear in the same cycle
		if (I_PAGE_STROBE && I_MODE_BASEX && !I_NONEG_PARTNER)
			page_rx_r <= 1'b1;
		else if (rd_clr_r)
			page_rx_r <= 1'b0;
		if (I_PAGE_STROBE && !I_NP_SENT)
			toggle_r <= ~I_BASE_TOGGLE;
		else if (I_NP_SENT)
			toggle_r <= ~toggle_r;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Link timers
reg [20:0] go_cnt_r;
reg [20:0] sf_cnt_r;
wire [20:0] go_len = ctrl_r[`TAM_CTRL_FAST_SIM] ? `TAM_FAST_CYCLES :
	(ctrl_r[`TAM_CTRL_GO_LINK_SEL] ? GO_LINK_LONG : GO_LINK_SHORT);
wire [20:0] sf_len = ctrl_r[`TAM_CTRL_FAST_SIM] ? `TAM_FAST_CYCLES :
	`TAM_SYNC_FAIL_CYCLES;

always @(posedge I_CLK_SYS)
begin
	if (!I_RST_B || ctrl_r[`TAM_CTRL_SOFT_RST])
	begin
		go_cnt_r         <= 21'h000000;
		sf_cnt_r         <= 21'h000000;
		O_GO_LINK_DONE   <= 1'b0;
		O_SYNC_FAIL_DONE <= 1'b0;
	end
	else
	begin
		O_GO_LINK_DONE   <= (go_cnt_r == 21'h000001);
		O_SYNC_FAIL_DONE <= (sf_cnt_r == 21'h000001);
		go_cnt_r <= I_GO_LINK_START ? go_len : dec21(go_cnt_r);
		sf_cnt_r <= I_SYNC_FAIL_START ? sf_len : dec21(sf_cnt_r);
	end
end

////////////////////////////////////////////////////////////////////////////////
// Jitter pattern generator and control outputs
reg [19:0] pat_r;
reg [9:0]  lfsr_r;

always @(posedge I_CLK_SYS)
begin
	if (!I_RST_B)
	begin
		pat_r           <= 20'h00000;
		lfsr_r          <= 10'h001;
		O_JITTER_ACTIVE <= 1'b0;
		O_JITTER_WORD   <= 10'h000;
		O_SUB_RESET     <= 1'b1;
		O_RX_RD_DIS     <= 1'b0;
		O_TX_RD_DIS     <= 1'b0;
		O_AN_SENSE_DONE <= 1'b0;
		O_NP_TX_WORD    <= `TAM_NP_TX_RESET;
	end
	else
	begin
		O_SUB_RESET     <= ctrl_r[`TAM_CTRL_SOFT_RST];
		O_RX_RD_DIS     <= ctrl_r[`TAM_CTRL_RX_RD_DIS];
		O_TX_RD_DIS     <= ctrl_r[`TAM_CTRL_TX_RD_DIS];
		O_AN_SENSE_DONE <= ctrl_r[`TAM_CTRL_AN_SENSE] & I_NONEG_PARTNER;
		O_NP_TX_WORD    <= np_tx_view;
		O_JITTER_ACTIVE <= jit_r[15];
		lfsr_r <= {lfsr_r[8:0], lfsr_r[9] ^ lfsr_r[6]};
		// Two-word patterns alternate halves each cycle
		case (jit_r[14:12])
			`TAM_PAT_HIGH_FREQ: pat_r <= `TAM_PAT_HIGH_VAL;
			`TAM_PAT_MIXED: pat_r <= (pat_r == `TAM_PAT_MIXED_VAL) ? rot20(pat_r) : `TAM_PAT_MIXED_VAL;
			`TAM_PAT_CUSTOM_LOW,
			`TAM_PAT_STD_LOW: pat_r <= (pat_r == `TAM_PAT_LOW_VAL) ? rot20(pat_r) : `TAM_PAT_LOW_VAL;
			default: pat_r <= 20'h00000;
		endcase
		case (jit_r[14:12])
			`TAM_PAT_CUSTOM: O_JITTER_WORD <= jit_r[9:0];
			`TAM_PAT_RANDOM: O_JITTER_WORD <= lfsr_r;
			`TAM_PAT_HIGH_FREQ, `TAM_PAT_MIXED,
			`TAM_PAT_CUSTOM_LOW, `TAM_PAT_STD_LOW: O_JITTER_WORD <= pat_r[19:10];
			default: O_JITTER_WORD <= 10'h000;
		endcase
	end
end

endmodule

/* core/tam_regs_map.vh */
// Register map constants for the upper management register bank.
// Assumes a clause 22 MDIO frame format and a 100 MHz system clock.
`ifndef TAM_REGS_MAP_VH
`define TAM_REGS_MAP_VH

`define TAM_REG_PARTNER_BASE  5'h05
`define TAM_REG_EXPANSION     5'h06
`define TAM_REG_NP_TX         5'h07
`define TAM_REG_PARTNER_NP    5'h08
`define TAM_REG_EXT_STATUS    5'h0F
`define TAM_REG_JITTER        5'h10
`define TAM_REG_LINK_CTRL     5'h11

`define TAM_EXP_NP_ABLE       2
`define TAM_EXP_PAGE_RX       1
`define TAM_EXT_STATUS_VAL    16'hA000
`define TAM_NP_TX_RESET       16'h2001
`define TAM_JIT_RESET         16'h0000
`define TAM_CTRL_RESET        16'h0000
`define TAM_NP_TX_WMASK       16'hB7FF
`define TAM_JIT_WMASK         16'hF3FF
`define TAM_CTRL_WMASK        16'hF900

`define TAM_CTRL_SOFT_RST     15
`define TAM_CTRL_FAST_SIM     14
`define TAM_CTRL_RX_RD_DIS    13
`define TAM_CTRL_TX_RD_DIS    12
`define TAM_CTRL_GO_LINK_SEL  11
`define TAM_CTRL_AN_SENSE     8

`define TAM_PAT_CUSTOM        3'h0
`define TAM_PAT_HIGH_FREQ     3'h1
`define TAM_PAT_MIXED         3'h2
`define TAM_PAT_CUSTOM_LOW    3'h3
`define TAM_PAT_RANDOM        3'h4
`define TAM_PAT_STD_LOW       3'h5
`define TAM_PAT_MIXED_VAL     20'hFAC14
`define TAM_PAT_LOW_VAL       20'hF83E0
`define TAM_PAT_HIGH_VAL      20'hAAAAA

`define TAM_FAST_CYCLES       21'h000040
`define TAM_GO_LINK_CYCLES    21'h030D40
`define TAM_GO_LINK_LONG      21'h0F4240
`define TAM_SYNC_FAIL_CYCLES  21'h1312D0
`endif

/* tb/tam_mdio_mgr.sv */
// Station manager model: clause 22 frames on a pulled-up data line.
// Assumes the bench resolves the line; MDC rests low between frames.
module tam_mdio_mgr
(
	input  wire logic clk,
	input  wire logic mdio_in,
	output logic      mdc,
	output logic      mdo,
	output logic      mdo_en
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		mdc = 1'b0;
		mdo = 1'b1;
		mdo_en = 1'b0;
	end
	////////////////////////////////////////
	// Sample late in the high phase: the bank answers a few clocks after MDC falls
	task automatic bit_cyc(input logic b, output logic s);
		mdo = b;
		repeat (4) @(negedge clk);
		mdc = 1'b1;
		repeat (4) @(negedge clk);
		s = mdio_in;
		mdc = 1'b0;
	endtask
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [31:0] hdr;
		logic        s;
		hdr = {2'b01, op, phy, ra, op[1] ? 2'b11 : 2'b10, wd};
		// Gap between frames, so the enable never drops and rises at once
		@(negedge clk);
		mdo_en = 1'b1;
		for (int i = 0; i < 64; i++)
		begin
			if (i == 46 && op[1])
				mdo_en = 1'b0;
			bit_cyc(i < 32 ? 1'b1 : hdr[63 - i], s);
			rd = {rd[14:0], s};
		end
		mdo_en = 1'b0;
	endtask
endmodule

/* tb/tam_regs_checker.sv */
// Concurrent checks on the register bank ports.
// Assumes one clock domain with synchronous active-low reset.
module tam_regs_checker
(
	input wire logic        I_CLK_SYS,
	input wire logic        I_RST_B,
	input wire logic        O_MDIO,
	input wire logic        O_MDIO_OE,
	input wire logic        I_NONEG_PARTNER,
	input wire logic        I_NP_SENT,
	input wire logic        I_MODE_BASEX,
	input wire logic        O_SUB_RESET,
	input wire logic        O_RX_RD_DIS,
	input wire logic        O_AN_SENSE_DONE,
	input wire logic        O_GO_LINK_DONE,
	input wire logic        O_SYNC_FAIL_DONE,
	input wire logic        I_GO_LINK_START,
	input wire logic        I_SYNC_FAIL_START,
	input wire logic [15:0] O_NP_TX_WORD
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RST_B);
	////////////////////////////////////////
	a_ta_bit_zero: assert property ($rose(O_MDIO_OE) |-> !O_MDIO)
		else $error("turnaround bit not low");
	a_read_oe_hold: assert property ($rose(O_MDIO_OE) |-> O_MDIO_OE[*8])
		else $error("read drive too short");
	a_rd_dis_write: assert property ($changed(O_RX_RD_DIS) |-> !O_MDIO_OE)
		else $error("disparity control moved during read");
	a_soft_rst_write: assert property ($changed(O_SUB_RESET) |-> !O_MDIO_OE)
		else $error("soft reset moved during read");
	a_sense_cause: assert property (O_AN_SENSE_DONE |-> $past(I_NONEG_PARTNER))
		else $error("sense done without partner");
	a_sense_drop: assert property (!I_NONEG_PARTNER |=> !O_AN_SENSE_DONE)
		else $error("sense done stuck");
	a_go_pulse_once: assert property (O_GO_LINK_DONE |=> !O_GO_LINK_DONE)
		else $error("go link done too long");
	a_go_min_wait: assert property (I_GO_LINK_START |=> !O_GO_LINK_DONE[*8])
		else $error("go link expired early");
	a_sync_min_wait: assert property (I_SYNC_FAIL_START |=> !O_SYNC_FAIL_DONE[*8])
		else $error("sync fail expired early");
	a_toggle_flip: assert property (I_NP_SENT && I_MODE_BASEX |-> ##[1:4] $changed(O_NP_TX_WORD[11]))
		else $error("toggle did not flip");
	c_read: cover property ($rose(O_MDIO_OE));
	c_go_done: cover property (O_GO_LINK_DONE);
	c_sense: cover property (O_AN_SENSE_DONE);
endmodule
bind tam_regs tam_regs_checker tam_regs_checker_i (.I_CLK_SYS(I_CLK_SYS), .I_RST_B(I_RST_B),
	.O_MDIO(O_MDIO), .O_MDIO_OE(O_MDIO_OE), .I_NONEG_PARTNER(I_NONEG_PARTNER),
	.I_NP_SENT(I_NP_SENT), .O_SUB_RESET(O_SUB_RESET), .O_RX_RD_DIS(O_RX_RD_DIS),
	.O_AN_SENSE_DONE(O_AN_SENSE_DONE), .O_GO_LINK_DONE(O_GO_LINK_DONE),
	.O_SYNC_FAIL_DONE(O_SYNC_FAIL_DONE), .I_GO_LINK_START(I_GO_LINK_START),
	.I_SYNC_FAIL_START(I_SYNC_FAIL_START), .O_NP_TX_WORD(O_NP_TX_WORD),
	.I_MODE_BASEX(I_MODE_BASEX));

/* tb/testbench.sv */
// Self-checking bench for the register bank.
// Assumes the manager model drives MDIO; the bench drives partner state.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rst_b, mdc, mdo, mdo_en, mode, pstb, noneg, npsent, btog, gls, sfs;
	logic [15:0] pbase, pnp, rd;
	logic [4:0]  tgt;
	wire         mo, moe, subr, rxd, txd, sense, gld, sfd, jact;
	wire  [9:0]  jword;
	wire  [15:0] npw;
	wire         line = moe ? mo : (mdo_en ? mdo : 1'b1);
	int          fail_count = 0;
	int          n_checks = 0;
	int          cyc = 0;
	tam_regs tam_regs_i (.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_MDC(mdc), .I_MDIO(line),
		.O_MDIO(mo), .O_MDIO_OE(moe), .I_PHY_ADDR(5'h0A), .I_MODE_BASEX(mode),
		.I_PARTNER_BASE(pbase), .I_PARTNER_NP(pnp), .I_PAGE_STROBE(pstb),
		.I_NONEG_PARTNER(noneg), .I_NP_SENT(npsent), .I_BASE_TOGGLE(btog),
		.O_SUB_RESET(subr), .O_RX_RD_DIS(rxd), .O_TX_RD_DIS(txd), .O_AN_SENSE_DONE(sense),
		.O_GO_LINK_DONE(gld), .O_SYNC_FAIL_DONE(sfd), .I_GO_LINK_START(gls),
		.I_SYNC_FAIL_START(sfs), .O_JITTER_ACTIVE(jact), .O_JITTER_WORD(jword),
		.O_NP_TX_WORD(npw));
	tam_mdio_mgr tam_mdio_mgr_i (.clk(clk), .mdio_in(line), .mdc(mdc), .mdo(mdo),
		.mdo_en(mdo_en));
	////////////////////////////////////////
	task automatic cmp(input logic [15:0] got, exp);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd_reg(input logic [4:0] ra, input logic [15:0] exp);
		tam_mdio_mgr_i.frame(2'b10, tgt, ra, 16'h0000, rd);
		cmp(rd, exp);
	endtask
	// Let the write land through the pin synchronisers
	task automatic wr_reg(input logic [4:0] ra, input logic [15:0] wd);
		tam_mdio_mgr_i.frame(2'b01, tgt, ra, wd, rd);
		repeat (4) @(negedge clk);
	endtask
	task automatic timer(input logic sync);
		int n;
		n = 0;
		gls = !sync;
		sfs = sync;
		@(negedge clk);
		gls = 1'b0;
		sfs = 1'b0;
		while (!(sync ? sfd : gld) && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		cmp(16'(n >= 62 && n <= 68), 16'h0001);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			fail_count++;
			tally_and_finish();
		end
	end
	initial
	begin
		{rst_b, pstb, noneg, npsent, btog, gls, sfs} = 7'h00;
		mode = 1'b1;
		tgt = 5'h0A;
		pbase = 16'hB1E0;
		pnp = 16'h5A5A;
		repeat (8) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		cmp(16'(subr), 16'h0000);
		rd_reg(5'h0F, 16'hA000);
		rd_reg(5'h11, 16'h0000);
		rd_reg(5'h10, 16'h0000);
		rd_reg(5'h05, 16'hB1E0);
		rd_reg(5'h1F, 16'h0000);
		rd_reg(5'h06, 16'h0004);
		pstb = 1'b1;
		@(negedge clk);
		pstb = 1'b0;
		rd_reg(5'h06, 16'h0006);
		rd_reg(5'h06, 16'h0004);
		wr_reg(5'h07, 16'hFFFF);
		cmp(npw, 16'hBFFF);
		rd_reg(5'h07, 16'hBFFF);
		npsent = 1'b1;
		@(negedge clk);
		npsent = 1'b0;
		repeat (4) @(negedge clk);
		cmp(16'(npw[11]), 16'h0000);
		wr_reg(5'h08, 16'h0000);
		rd_reg(5'h08, 16'h1A5A);
		mode = 1'b0;
		rd_reg(5'h08, 16'h5A5A);
		rd_reg(5'h05, 16'h9001);
		wr_reg(5'h07, 16'hFFFF);
		rd_reg(5'h07, 16'hFFFF);
		wr_reg(5'h10, 16'h83A5);
		cmp({5'h00, jact, jword}, 16'h07A5);
		wr_reg(5'h10, 16'h1000);
		cmp(16'(jword), 16'h02AA);
		wr_reg(5'h10, 16'h3000);
		rd_reg(5'h10, 16'h3000);
		cmp(16'(jword), 16'h03E0);
		cmp(16'(jact), 16'h0000);
		wr_reg(5'h11, 16'hFFFF);
		rd_reg(5'h11, 16'hF900);
		cmp(16'({subr, rxd, txd}), 16'h0007);
		wr_reg(5'h11, 16'h4100);
		timer(1'b0);
		timer(1'b1);
		noneg = 1'b1;
		repeat (4) @(negedge clk);
		cmp(16'(sense), 16'h0001);
		rd_reg(5'h06, 16'h0004);
		tgt = 5'h0B;
		rd_reg(5'h0F, 16'hFFFF);
		tally_and_finish();
	end
endmodule
